// ### hw/dpl_loader.sv
// decimating pixel loader: six channel latches, transfer stage, apb slave
// assumes pins asynchronous to CLK_I; pixel clock much slower than CLK_I
`timescale 1ns/1ps
`default_nettype none

module dpl_loader (
  input  wire logic                   CLK_I,
  input  wire logic                   RSTN_I,
  input  wire dpl_pkg::dpl_pins_t     PINS_I,
  input  wire logic                   PSEL_I,
  input  wire logic                   PENABLE_I,
  input  wire logic                   PWRITE_I,
  input  wire logic [11:0]            PADDR_I,
  input  wire logic [31:0]            PWDATA_I,
  output var  logic [31:0]            PRDATA_O,
  output var  logic                   PREADY_O,
  output var  logic                   PSLVERR_O,
  output var  dpl_pkg::dpl_channels_t CHANNEL_OUTPUTS_O,
  output var  logic                   POLARITY_O
);

  dpl_pkg::dpl_pins_t     pins_meta_reg;
  dpl_pkg::dpl_pins_t     pins_sync_reg;
  logic                   pclk_prev_reg;
  logic                   rise;
  logic                   fall;
  logic                   active_edge;
  logic                   start_seen_reg;
  logic                   dir_reg;
  logic [2:0]             idx_reg;
  logic [2:0]             cnt_reg;
  dpl_pkg::dpl_channels_t latch_reg;
  logic                   xfr_pend_reg;
  logic                   pol_latch_reg;
  logic                   load_en_reg;
  logic                   setup;
  logic                   wr_access;
  logic [31:0]            rdata_next;
  logic                   err_next;

  function automatic logic [2:0] step_idx(input logic [2:0] idx,
                                          input logic       right);
    step_idx = right ? idx - 3'h1 : idx + 3'h1;
  endfunction

  function automatic logic [2:0] first_idx(input logic right);
    first_idx = right ? dpl_pkg::FIRST_CH_RIGHT : dpl_pkg::FIRST_CH_LEFT;
  endfunction

  // two-stage synchroniser; word and clock share latency so data stays aligned
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
    end else begin
      pins_meta_reg <= PINS_I;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pclk_prev_reg <= 1'b0;
    end else begin
      pclk_prev_reg <= pins_sync_reg.pixel_clock;
    end
  end

  assign rise = pins_sync_reg.pixel_clock & ~pclk_prev_reg;
  assign fall = ~pins_sync_reg.pixel_clock & pclk_prev_reg;
  assign active_edge = pins_sync_reg.edge_select ? rise : fall;

  // start flag: sampled every active edge, acted on at the next one
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      start_seen_reg <= 1'b0;
    end else if (active_edge) begin
      start_seen_reg <= pins_sync_reg.sequence_start;
    end
  end

  // loading sequencer; a fresh start restarts even a half-filled sequence
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      dir_reg   <= 1'b0;
      idx_reg   <= dpl_pkg::FIRST_CH_LEFT;
      cnt_reg   <= dpl_pkg::LOAD_COUNT;
      latch_reg <= '0;
    end else if (active_edge && load_en_reg) begin
      if (start_seen_reg) begin
        dir_reg <= pins_sync_reg.direction_select;
        latch_reg.word[first_idx(pins_sync_reg.direction_select)] <=
          pins_sync_reg.pixel_word_in;
        idx_reg <= step_idx(first_idx(pins_sync_reg.direction_select),
                            pins_sync_reg.direction_select);
        cnt_reg <= 3'h1;
      end else if (cnt_reg < dpl_pkg::LOAD_COUNT) begin
        latch_reg.word[idx_reg] <= pins_sync_reg.pixel_word_in;
        idx_reg <= step_idx(idx_reg, dir_reg);
        cnt_reg <= cnt_reg + 3'h1;
      end
    end
  end

  // transfer detection and output stage, rising pixel edges only
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      xfr_pend_reg <= 1'b0;
    end else if (rise) begin
      xfr_pend_reg <= pins_sync_reg.output_transfer;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      CHANNEL_OUTPUTS_O <= '0;
      POLARITY_O        <= 1'b0;
      pol_latch_reg     <= 1'b0;
    end else if (rise && xfr_pend_reg) begin
      CHANNEL_OUTPUTS_O <= latch_reg;
      POLARITY_O        <= pol_latch_reg;
      pol_latch_reg     <= pins_sync_reg.polarity_invert;
    end
  end

  // apb slave: zero wait states, answer prepared in the setup cycle
  assign setup     = PSEL_I & ~PENABLE_I;
  assign wr_access = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (PADDR_I == dpl_pkg::ADDR_CTRL) begin
      rdata_next[dpl_pkg::CTRL_LOAD_EN_BIT] = load_en_reg;
    end else if (PADDR_I == dpl_pkg::ADDR_STATUS) begin
      rdata_next[dpl_pkg::STAT_IDX_LSB +: 3] = idx_reg;
      rdata_next[dpl_pkg::STAT_CNT_LSB +: 3] = cnt_reg;
      rdata_next[dpl_pkg::STAT_START_BIT]    = start_seen_reg;
      rdata_next[dpl_pkg::STAT_OUT_POL_BIT]  = POLARITY_O;
      rdata_next[dpl_pkg::STAT_LAT_POL_BIT]  = pol_latch_reg;
      rdata_next[dpl_pkg::STAT_XFR_PEND_BIT] = xfr_pend_reg;
    end else if (PADDR_I >= dpl_pkg::ADDR_CH0 &&
                 PADDR_I <= dpl_pkg::ADDR_CH5 && PADDR_I[1:0] == 2'h0) begin
      rdata_next[dpl_pkg::WORD_W-1:0] =
        CHANNEL_OUTPUTS_O.word[3'(PADDR_I[4:2] - 3'h2)];
    end else begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= setup;
      PSLVERR_O <= setup & err_next;
      if (setup) begin
        PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rdata_next;
      end
    end
  end

  // only the control word is writable; other writes are ignored, with error only at unmapped addresses
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      load_en_reg <= dpl_pkg::CTRL_LOAD_EN_RST;
    end else if (wr_access && PADDR_I == dpl_pkg::ADDR_CTRL) begin
      load_en_reg <= PWDATA_I[dpl_pkg::CTRL_LOAD_EN_BIT];
    end
  end

endmodule

`default_nettype wire

// ### shared/dpl_pkg.sv
// package for the decimating pixel loader: pin bundle, register map, resets
// assumes a single core clock; all pins arrive asynchronous to it
`default_nettype none
package dpl_pkg;

  localparam int unsigned WORD_W   = 10;
  localparam int unsigned CHANNELS = 6;
  localparam int unsigned IDX_W    = 3;

  localparam logic [IDX_W-1:0] FIRST_CH_LEFT  = 3'h0;
  localparam logic [IDX_W-1:0] FIRST_CH_RIGHT = 3'h5;
  localparam logic [IDX_W-1:0] LOAD_COUNT     = 3'h6;

  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CH0    = 12'h008;
  localparam logic [11:0] ADDR_CH5    = 12'h01c;

  localparam int unsigned CTRL_LOAD_EN_BIT  = 0;
  localparam logic        CTRL_LOAD_EN_RST  = 1'b1;
  localparam int unsigned STAT_IDX_LSB      = 0;
  localparam int unsigned STAT_CNT_LSB      = 3;
  localparam int unsigned STAT_START_BIT    = 6;
  localparam int unsigned STAT_OUT_POL_BIT  = 7;
  localparam int unsigned STAT_LAT_POL_BIT  = 8;
  localparam int unsigned STAT_XFR_PEND_BIT = 9;

  typedef logic [WORD_W-1:0] dpl_word_t;

  typedef struct packed {
    logic      pixel_clock;
    dpl_word_t pixel_word_in;
    logic      sequence_start;
    logic      edge_select;
    logic      direction_select;
    logic      output_transfer;
    logic      polarity_invert;
  } dpl_pins_t;

  typedef struct packed {
    dpl_word_t [CHANNELS-1:0] word;
  } dpl_channels_t;

endpackage

`default_nettype wire

// ### test/dpl_loader_monitor.sv
// checker: apb answer timing and output update moments of the loader
// assumes pixel clock phases of at least three core clock periods
`timescale 1ns/1ps
`default_nettype none
module dpl_loader_monitor (
  input wire logic                   CLK_I,
  input wire logic                   RSTN_I,
  input wire dpl_pkg::dpl_pins_t     PINS_I,
  input wire logic                   PSEL_I,
  input wire logic                   PENABLE_I,
  input wire logic                   PWRITE_I,
  input wire logic [31:0]            PRDATA_O,
  input wire logic                   PREADY_O,
  input wire logic                   PSLVERR_O,
  input wire dpl_pkg::dpl_channels_t CHANNEL_OUTPUTS_O,
  input wire logic                   POLARITY_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_setup; PSEL_I && !PENABLE_I; endsequence
  // outputs may only move once a pixel rise has passed the syncs
  sequence s_pix_hi; $past(PINS_I.pixel_clock, 2); endsequence
  property p_rdy; s_setup |=> PREADY_O; endproperty
  property p_one; PREADY_O |=> !PREADY_O; endproperty
  property p_cause; PREADY_O |-> $past(PSEL_I) && !$past(PENABLE_I);
  endproperty
  property p_err_rdy; PSLVERR_O |-> PREADY_O; endproperty
  property p_err_zero; PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0;
  endproperty
  property p_hold; !(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O);
  endproperty
  property p_ch_edge; $changed(CHANNEL_OUTPUTS_O) |-> s_pix_hi; endproperty
  property p_pol_edge; $changed(POLARITY_O) |-> s_pix_hi; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready too long");
  a_cause: assert property (p_cause) else $error("ready without setup");
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  a_err_zero: assert property (p_err_zero) else $error("error data not 0");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_ch_edge: assert property (p_ch_edge) else $error("outputs off edge");
  a_pol_edge: assert property (p_pol_edge) else $error("pol off edge");
endmodule
bind dpl_loader dpl_loader_monitor dpl_loader_monitor_i (.CLK_I(CLK_I),
  .RSTN_I(RSTN_I), .PINS_I(PINS_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .CHANNEL_OUTPUTS_O(CHANNEL_OUTPUTS_O), .POLARITY_O(POLARITY_O));
`default_nettype wire

// ### test/dpl_tcon_model.sv
// timing controller model: drives the pixel pin bundle pulse by pulse
// assumes the bench calls its tasks right after a core clock edge
`timescale 1ns/1ps
`default_nettype none
module dpl_tcon_model (
  input  wire logic               clk_i,
  output var  dpl_pkg::dpl_pins_t pins_o
);
  initial pins_o = '0;
  task automatic mode(input logic e, d);
    pins_o.edge_select <= e;
    pins_o.direction_select <= d;
    repeat (4) @(posedge clk_i);
  endtask
  // pixel clock idles low between pulses
  task automatic pulse(input dpl_pkg::dpl_word_t w, input logic s, x, p);
    pins_o.pixel_word_in <= w;
    pins_o.sequence_start <= s;
    pins_o.output_transfer <= x;
    pins_o.polarity_invert <= p;
    repeat (4) @(posedge clk_i);
    pins_o.pixel_clock <= 1'b1;
    repeat (4) @(posedge clk_i);
    pins_o.pixel_clock <= 1'b0;
    repeat (3) @(posedge clk_i);
    // hold time over: never leave a stale word on the bus
    pins_o.pixel_word_in <= ~w;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### test/dpl_loader_tb_top.sv
// testbench: apb access, loading in both modes, transfer and polarity
// assumes the partner model owns the pixel pins, the bench owns apb
`timescale 1ns/1ps
`default_nettype none
module dpl_loader_tb_top;
  logic clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, lfsr_q = 32'hd96fdc42;
  logic pready, pslverr, pol, err;
  dpl_pkg::dpl_pins_t pins;
  dpl_pkg::dpl_channels_t chans;
  int fail_count = 0, n_checks = 0, exp_ch[6] = '{default: 0};
  int exp_pol = 0, lat_pol = 0;
  always #20 clk_i = ~clk_i;
  dpl_loader dpl_loader_i (.CLK_I(clk_i), .RSTN_I(rstn_i), .PINS_I(pins),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CHANNEL_OUTPUTS_O(chans), .POLARITY_O(pol));
  dpl_tcon_model dpl_tcon_model_i (.clk_i(clk_i), .pins_o(pins));
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic frame(input logic e, d, input int n);
    int idx;
    idx = d ? 5 : 0;
    dpl_tcon_model_i.mode(e, d);
    dpl_tcon_model_i.pulse('0, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      lfsr_q = nx(lfsr_q);
      if (i < 6) exp_ch[idx] = int'(lfsr_q[9:0]);
      idx = d ? idx - 1 : idx + 1;
      dpl_tcon_model_i.pulse(lfsr_q[9:0], 1'b0, 1'b0, 1'b0);
    end
  endtask
  task automatic xfer(input logic p);
    dpl_tcon_model_i.pulse('0, 1'b0, 1'b1, p);
    // polarity is taken at the rise after detection, so keep it there too
    dpl_tcon_model_i.pulse('0, 1'b0, 1'b0, p);
    exp_pol = lat_pol;
    lat_pol = int'(p);
    for (int i = 0; i < 6; i++) chk(32'(chans.word[i]), exp_ch[i]);
    chk(32'(pol), exp_pol);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    apb(1'b0, dpl_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'(dpl_pkg::CTRL_LOAD_EN_RST) << dpl_pkg::CTRL_LOAD_EN_BIT);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, dpl_pkg::ADDR_CTRL, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, dpl_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, dpl_pkg::ADDR_CTRL, 32'h1);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, dpl_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    $display("test regs done");
    frame(1'b1, 1'b0, 6);
    xfer(1'b1);
    $display("test rise left done");
    frame(1'b0, 1'b1, 7);
    xfer(1'b0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, dpl_pkg::ADDR_CH0 + 12'(4 * i), 32'h0);
      chk(rd, exp_ch[i]);
    end
    $display("test fall right done");
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
